// ---- verilog/ccel_top.sv ----
// comparator channel control register, routing selects and edge event logic.
// assumes an avalon-mm master on core_clk and an analog comparator whose raw
// result arrives asynchronously on raw_result.
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
// Overview of operation
// - code 11 triggers on any change
// - code 10 triggers on adjusted falling edge
// - code 01 triggers on adjusted rising edge
// - code 00 never triggers
// - positive select: reference or pin one
// - negative select picks pins one to four
// - unimplemented control bits read zero
// - unbonded selected input tied to ground
// - amplifier power independent of comparator
// - pin drive shows result on pin
// - sticky flag set, blocks further events
// - invert applies before status, pin, detector
module ccel_top #(
   parameter logic                                 POS_PIN_BONDED = 1'b1,
   parameter logic [ccel_pkg::CCEL_NEG_PINS-1:0]   NEG_PIN_BONDED = 4'hF
) (
   input  wire logic                               core_clk,
   input  wire logic                               rst,
   input  wire logic [3:0]                         address,
   input  wire logic                               read,
   input  wire logic                               write,
   input  wire logic [ccel_pkg::CCEL_DATA_W-1:0]   writedata,
   input  wire logic [3:0]                         byteenable,
   output logic [ccel_pkg::CCEL_DATA_W-1:0]        readdata,
   output logic                                    waitrequest,
   input  wire logic                               raw_result,
   output logic                                    channel_on,
   output logic                                    amplifier_power_on,
   output logic                                    positive_input_select,
   output logic [1:0]                              negative_input_select,
   output logic                                    positive_input_ground,
   output logic                                    negative_input_ground,
   output logic                                    channel_result_pin,
   output logic                                    channel_result_pin_oe_n,
   output logic                                    event_trigger,
   output logic                                    irq
);
   import ccel_pkg::*;

   // ----------------------------------------------------------------
   // storage and decode
   // ----------------------------------------------------------------
   logic [CCEL_CTRL_W-1:0] control;
   logic [CCEL_IRQ_W-1:0]  irq_status;
   logic [CCEL_IRQ_W-1:0]  irq_mask;

   wire req        = read | write;
   wire accept     = req & ~waitrequest;
   wire wr_accept  = accept & write;
   wire sel_ctrl   = (address == CCEL_ADDR_CONTROL);
   wire sel_status = (address == CCEL_ADDR_STATUS);
   wire sel_mask   = (address == CCEL_ADDR_MASK);
   wire wr_ctrl    = wr_accept & sel_ctrl;
   wire wr_status  = wr_accept & sel_status;
   wire wr_mask    = wr_accept & sel_mask;

   // byte lanes expanded to a bit mask over the low half word
   wire [CCEL_CTRL_W-1:0] lane_mask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
   wire [CCEL_CTRL_W-1:0] ctrl_wmask = CCEL_CTRL_WMASK & lane_mask;

   // named fields of the control word
   wire        f_on    = control[CCEL_BIT_ON];
   wire        f_pin   = control[CCEL_BIT_PIN];
   wire        f_inv   = control[CCEL_BIT_INV];
   wire        f_amp   = control[CCEL_BIT_AMP];
   wire        f_evt   = control[CCEL_BIT_EVT];
   wire        f_pos   = control[CCEL_BIT_POS];
   wire [1:0]  f_neg   = control[CCEL_BIT_NEG_HI:CCEL_BIT_NEG_LO];
   wire [1:0]  f_edge  = control[CCEL_BIT_EDGE_HI:CCEL_BIT_EDGE_LO];

   // ----------------------------------------------------------------
   // result path and event detection
   // ----------------------------------------------------------------
   logic adj_result;
   logic res_rise;
   logic res_fall;

   ccel_result_sync u_sync (
      .core_clk   (core_clk),
      .rst        (rst),
      .raw_result (raw_result),
      .enable     (f_on),
      .invert     (f_inv),
      .adj_result (adj_result),
      .rise       (res_rise),
      .fall       (res_fall)
   );

   // edge match per select code; invert already folded into adj_result
   logic edge_hit;
   always_comb begin
      unique case (ccel_edge_t'(f_edge))
         CCEL_EDGE_OFF:  edge_hit = 1'b0;
         CCEL_EDGE_RISE: edge_hit = res_rise;
         CCEL_EDGE_FALL: edge_hit = res_fall;
         CCEL_EDGE_ANY:  edge_hit = res_rise | res_fall;
      endcase
   end

   // off channel never detects, sticky flag blocks everything
   wire event_now = edge_hit & f_on & ~f_evt;

   // ----------------------------------------------------------------
   // control register; hardware set of the sticky flag beats a write
   // ----------------------------------------------------------------
   wire [CCEL_CTRL_W-1:0] ctrl_written = (control & ~ctrl_wmask) | (writedata[CCEL_CTRL_W-1:0] & ctrl_wmask);
   wire [CCEL_CTRL_W-1:0] ctrl_base    = wr_ctrl ? ctrl_written : control;
   wire [CCEL_CTRL_W-1:0] ctrl_evt     = {{(CCEL_CTRL_W-1){1'b0}}, event_now} << CCEL_BIT_EVT;
   wire [CCEL_CTRL_W-1:0] next_control = (ctrl_base | ctrl_evt) & CCEL_CTRL_WMASK;

   always_ff @(posedge core_clk) begin
      if (rst) control <= CCEL_CTRL_RESET;
      else     control <= next_control;
   end

   // ----------------------------------------------------------------
   // interrupt status (write one clears, set wins) and mask
   // ----------------------------------------------------------------
   wire [CCEL_IRQ_W-1:0] stat_clr = (wr_status & byteenable[0]) ? writedata[CCEL_IRQ_W-1:0] : CCEL_IRQ_RESET;
   wire [CCEL_IRQ_W-1:0] next_irq_status = (irq_status & ~stat_clr) | {CCEL_IRQ_W{event_now}};

   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_status <= CCEL_IRQ_RESET;
         irq_mask   <= CCEL_IRQ_RESET;
         irq        <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         if (wr_mask & byteenable[0]) irq_mask <= writedata[CCEL_IRQ_W-1:0];
         irq        <= |(irq_status & irq_mask);
      end
   end

   // ----------------------------------------------------------------
   // avalon slave: one wait cycle, then the answer
   // ----------------------------------------------------------------
   // status bit is live, unimplemented bits read zero
   wire [CCEL_CTRL_W-1:0] ctrl_read = control | ({{(CCEL_CTRL_W-1){1'b0}}, adj_result} << CCEL_BIT_STAT);
   wire [CCEL_DATA_W-1:0] read_mux =
      sel_ctrl   ? {{(CCEL_DATA_W-CCEL_CTRL_W){1'b0}}, ctrl_read} :
      sel_status ? {{(CCEL_DATA_W-CCEL_IRQ_W){1'b0}}, irq_status} :
      sel_mask   ? {{(CCEL_DATA_W-CCEL_IRQ_W){1'b0}}, irq_mask} :
                   CCEL_ZERO_WORD;

   // waitrequest drops one cycle after a request arrives; readdata is loaded then
   always_ff @(posedge core_clk) begin
      if (rst) begin
         waitrequest <= 1'b1;
         readdata    <= CCEL_ZERO_WORD;
      end else begin
         waitrequest <= ~(req & waitrequest);
         if (read & waitrequest) readdata <= read_mux;
      end
   end

   // ----------------------------------------------------------------
   // analog side controls, all registered
   // ----------------------------------------------------------------
   // selects go to the analog mux; a missing pin grounds the input instead
   wire pos_gnd_now = ~f_pos & ~POS_PIN_BONDED;
   wire neg_gnd_now = ~NEG_PIN_BONDED[f_neg];

   always_ff @(posedge core_clk) begin
      if (rst) begin
         channel_on              <= 1'b0;
         amplifier_power_on      <= 1'b0;
         positive_input_select   <= 1'b0;
         negative_input_select   <= 2'b00;
         positive_input_ground   <= 1'b0;
         negative_input_ground   <= 1'b0;
         channel_result_pin      <= 1'b0;
         channel_result_pin_oe_n <= 1'b1;
         event_trigger           <= 1'b0;
      end else begin
         channel_on              <= f_on;
         amplifier_power_on      <= f_amp;
         positive_input_select   <= f_pos;
         negative_input_select   <= f_neg;
         positive_input_ground   <= pos_gnd_now;
         negative_input_ground   <= neg_gnd_now;
         channel_result_pin      <= f_pin & adj_result;
         channel_result_pin_oe_n <= ~f_pin;
         event_trigger           <= event_now;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_armed_free;
      f_on && !f_evt;
   endsequence

   sequence s_bus_wait;
      req && waitrequest;
   endsequence

   a_any_change_fires: assert property (@(posedge core_clk) disable iff (rst)
      (s_armed_free and (f_edge == CCEL_EDGE_ANY && (res_rise || res_fall))) |=> event_trigger)
      else $error("any-change mode missed an edge");

   a_fall_only_mode: assert property (@(posedge core_clk) disable iff (rst)
      (f_edge == CCEL_EDGE_FALL && f_on && !f_evt) |=> (event_trigger == $past(res_fall)))
      else $error("falling-edge mode fired on the wrong edge");

   a_rise_only_mode: assert property (@(posedge core_clk) disable iff (rst)
      (s_armed_free and (f_edge == CCEL_EDGE_RISE && res_rise)) |=> event_trigger && f_evt)
      else $error("rising-edge mode missed an edge");

   a_edge_off_quiet: assert property (@(posedge core_clk) disable iff (rst)
      (f_edge == CCEL_EDGE_OFF) |=> !event_trigger)
      else $error("event raised with detection off");

   a_pos_route: assert property (@(posedge core_clk) disable iff (rst)
      1'b1 |=> positive_input_select == $past(control[CCEL_BIT_POS]))
      else $error("positive select does not follow control");

   a_neg_route: assert property (@(posedge core_clk) disable iff (rst)
      1'b1 |=> negative_input_select == $past(f_neg))
      else $error("negative select does not follow control");

   a_unimpl_zero: assert property (@(posedge core_clk) disable iff (rst)
      (read && !waitrequest && sel_ctrl) |-> (readdata[12:11] == 2'b00 && readdata[5] == 1'b0
         && readdata[3:2] == 2'b00 && readdata[31:16] == 16'h0000))
      else $error("unimplemented control bits read nonzero");

   a_neg_ground: assert property (@(posedge core_clk) disable iff (rst)
      1'b1 |=> negative_input_ground == !NEG_PIN_BONDED[$past(f_neg)])
      else $error("unbonded negative input not grounded");

   a_amp_indep: assert property (@(posedge core_clk) disable iff (rst)
      (f_on && !f_amp) ##1 (f_on && !f_amp) |-> channel_on && !amplifier_power_on)
      else $error("amplifier power coupled to comparator");

   a_pin_drive: assert property (@(posedge core_clk) disable iff (rst)
      !f_pin |=> channel_result_pin_oe_n && !channel_result_pin)
      else $error("result pin driven while pin drive is off");

   a_sticky_blocks: assert property (@(posedge core_clk) disable iff (rst)
      event_trigger |-> f_evt ##1 !event_trigger)
      else $error("sticky flag failed to set or block");

   a_invert_status: assert property (@(posedge core_clk) disable iff (rst)
      f_on && f_pin |=> channel_result_pin == $past(adj_result))
      else $error("pin result differs from adjusted status");

   a_off_status_zero: assert property (@(posedge core_clk) disable iff (rst)
      !f_on ##1 !f_on |-> !adj_result && !event_now)
      else $error("disabled channel shows result or event");

   a_status_ro: assert property (@(posedge core_clk) disable iff (rst)
      1'b1 |-> control[CCEL_BIT_STAT] == 1'b0)
      else $error("status bit stored by a write");

   a_bus_answer: assert property (@(posedge core_clk) disable iff (rst)
      s_bus_wait |=> !waitrequest ##1 waitrequest)
      else $error("bus answer not after one wait cycle");

endmodule : ccel_top

// ---- include/ccel_pkg.sv ----
// package: register map, field positions and codes for the comparator
// channel control and event logic.
// assumes a 32-bit avalon-mm slave with byte addresses and one aligned word per register.
package ccel_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] CCEL_ADDR_CONTROL = 4'h0;  // comparator_channel_control
   localparam logic [3:0] CCEL_ADDR_STATUS  = 4'h4;  // sticky interrupt status, write one to clear
   localparam logic [3:0] CCEL_ADDR_MASK    = 4'h8;  // interrupt mask, same layout as status

   // ----------------------------------------------------------------
   // control register field positions
   // ----------------------------------------------------------------
   localparam int CCEL_BIT_ON      = 15;  // channel_on
   localparam int CCEL_BIT_PIN     = 14;  // result_pin_drive
   localparam int CCEL_BIT_INV     = 13;  // result_invert
   localparam int CCEL_BIT_AMP     = 10;  // amplifier_power_on
   localparam int CCEL_BIT_EVT     = 9;   // sticky_event_flag
   localparam int CCEL_BIT_STAT    = 8;   // result_status, read only
   localparam int CCEL_BIT_EDGE_HI = 7;   // event_edge_select
   localparam int CCEL_BIT_EDGE_LO = 6;
   localparam int CCEL_BIT_POS     = 4;   // positive_input_select
   localparam int CCEL_BIT_NEG_HI  = 1;   // negative_input_select
   localparam int CCEL_BIT_NEG_LO  = 0;

   localparam int CCEL_CTRL_W = 16;
   localparam int CCEL_DATA_W = 32;

   // bits software may store; status and unimplemented bits are not stored
   localparam logic [CCEL_CTRL_W-1:0] CCEL_CTRL_WMASK = 16'hE6D3;
   localparam logic [CCEL_CTRL_W-1:0] CCEL_CTRL_RESET = 16'h0000;

   // status and mask layout
   localparam int CCEL_IRQ_EVENT = 0;
   localparam int CCEL_IRQ_W     = 1;
   localparam logic [CCEL_IRQ_W-1:0] CCEL_IRQ_RESET = 1'h0;

   localparam logic [CCEL_DATA_W-1:0] CCEL_ZERO_WORD = 32'h0000_0000;

   // ----------------------------------------------------------------
   // event edge select codes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CCEL_EDGE_OFF  = 2'b00,
      CCEL_EDGE_RISE = 2'b01,
      CCEL_EDGE_FALL = 2'b10,
      CCEL_EDGE_ANY  = 2'b11
   } ccel_edge_t;

   // negative input pin count
   localparam int CCEL_NEG_PINS = 4;

endpackage : ccel_pkg

// ---- verilog/ccel_result_sync.sv ----
// synchroniser and edge finder for the raw comparator result.
// assumes the raw result is asynchronous to core_clk; enable and invert come from
// registers on core_clk.
`timescale 1ns/1ps
module ccel_result_sync (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic raw_result,
   input  wire logic enable,
   input  wire logic invert,
   output logic      adj_result,
   output logic      rise,
   output logic      fall
);
   import ccel_pkg::*;

   logic sync_a;
   logic sync_b;
   logic prev_result;
   logic en_d1;
   logic armed;

   // ----------------------------------------------------------------
   // two flop synchroniser; sync_a is read by sync_b only
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end else begin
         sync_a <= raw_result;
         sync_b <= sync_a;
      end
   end

   // polarity applied after sync, forced low while off
   always_ff @(posedge core_clk) begin
      if (rst) begin
         adj_result  <= 1'b0;
         prev_result <= 1'b0;
         en_d1       <= 1'b0;
         armed       <= 1'b0;
      end else begin
         adj_result  <= enable & (sync_b ^ invert);
         prev_result <= adj_result;
         en_d1       <= enable;
         armed       <= en_d1 & enable;
      end
   end

   // armed waits two cycles so switching on never looks like an edge
   assign rise = armed & enable & adj_result & ~prev_result;
   assign fall = armed & enable & ~adj_result & prev_result;

endmodule : ccel_result_sync

// ---- tb/ccel_cmp_model.sv ----
// analog comparator stand-in: turns the levels on the selected inputs into a raw result.
// assumes the testbench sets pin and reference levels; ground flags come from the design.
`timescale 1ns/1ps
module ccel_cmp_model (
   input  wire logic       positive_input_select,
   input  wire logic [1:0] negative_input_select,
   input  wire logic       positive_input_ground,
   input  wire logic       negative_input_ground,
   input  wire logic [7:0] ref_level,
   input  wire logic [7:0] pos_level,
   input  wire logic [7:0] neg_level,
   output logic            raw_result
);
   // ----------------------------------------------------------------
   // input routing
   // ----------------------------------------------------------------
   wire logic [7:0] vin_p;
   wire logic [7:0] vin_n;

   // an unbonded selected input sits at ground; each negative pin gets its own level
   assign vin_p = positive_input_ground ? 8'h00 : (positive_input_select ? ref_level : pos_level);
   assign vin_n = negative_input_ground ? 8'h00 : neg_level + {6'h00, negative_input_select};

   // delayed so the raw result never moves on a clock edge, as a real comparator would not
   assign #3 raw_result = (vin_p > vin_n);
endmodule : ccel_cmp_model

// ---- tb/tb.sv ----
// testbench: register access over avalon-mm, edge events, sticky flag and interrupt.
// assumes ccel_pkg is compiled first and the comparator model drives raw_result.
`timescale 1ns/1ps
module tb;
   import ccel_pkg::*;
   localparam logic [3:0] NEG_BONDED = 4'h5;  // pins two and four absent
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  address = 4'h0;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [3:0]  byteenable = 4'hF;
   logic [31:0] readdata;
   logic        waitrequest, raw_result, channel_on, amplifier_power_on, positive_input_select;
   logic [1:0]  negative_input_select;
   logic        positive_input_ground, negative_input_ground, channel_result_pin;
   logic        channel_result_pin_oe_n, event_trigger, irq;
   logic [7:0]  ref_level = 8'h00;
   logic [7:0]  pos_level = 8'h00;
   int          bad_count = 0, samples_checked = 0, cycles = 0, trig_count = 0;
   integer      seed;

   ccel_top #(.POS_PIN_BONDED(1'b0), .NEG_PIN_BONDED(NEG_BONDED)) ccel_top_i (
      .core_clk(core_clk), .rst(rst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .raw_result(raw_result), .channel_on(channel_on), .amplifier_power_on(amplifier_power_on),
      .positive_input_select(positive_input_select), .negative_input_select(negative_input_select),
      .positive_input_ground(positive_input_ground), .negative_input_ground(negative_input_ground),
      .channel_result_pin(channel_result_pin), .channel_result_pin_oe_n(channel_result_pin_oe_n),
      .event_trigger(event_trigger), .irq(irq));

   ccel_cmp_model ccel_cmp_model_i (
      .positive_input_select(positive_input_select), .negative_input_select(negative_input_select),
      .positive_input_ground(positive_input_ground), .negative_input_ground(negative_input_ground),
      .ref_level(ref_level), .pos_level(pos_level), .neg_level(8'h40), .raw_result(raw_result));

   // ----------------------------------------------------------------
   // clock, timeout and event pulse counter
   // ----------------------------------------------------------------
   always #4 core_clk = ~core_clk;

   // about 440 cycles are needed; the ceiling leaves wide margin
   always @(posedge core_clk) begin
      cycles++;
      if (event_trigger === 1'b1) trig_count++;
      if (cycles == 20000) begin
         bad_count++;
         summarize();
      end
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check_word

   task automatic check_bit(input logic got, input logic exp, input string what);
      check_word({31'h0, got}, {31'h0, exp}, what);
   endtask : check_bit

   // one avalon transfer; a fresh edge first so no signal is driven twice in one step
   task automatic bus_xfer(input logic wr, input logic [3:0] addr, input logic [31:0] data,
                           output logic [31:0] rdata);
      int n;
      n = 0;
      @(posedge core_clk);
      address   <= addr;
      writedata <= data;
      read      <= ~wr;
      write     <= wr;
      @(posedge core_clk);
      while (waitrequest !== 1'b0 && n < 50) begin
         @(posedge core_clk);
         n++;
      end
      rdata = readdata;
      read  <= 1'b0;
      write <= 1'b0;
      if (n >= 50) begin
         bad_count++;
         $display("FAIL %0t bus transfer got no answer", $time);
      end
   endtask : bus_xfer

   task automatic wr_reg(input logic [3:0] addr, input logic [31:0] data);
      logic [31:0] d;
      bus_xfer(1'b1, addr, data, d);
   endtask : wr_reg

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] d, r;
      logic [15:0] c, e;
      logic        inv, e1, e2;
      logic [1:0]  code;
      seed = 32'hF304;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      // random control words with the channel off: storage, routing and grounding
      for (int i = 0; i < 8; i++) begin
         d = $random(seed);
         d[15] = 1'b0;
         pos_level <= d[23:16];
         wr_reg(CCEL_ADDR_CONTROL, d);
         bus_xfer(1'b0, CCEL_ADDR_CONTROL, 32'h0, r);
         check_word(r, {16'h0000, d[15:0] & CCEL_CTRL_WMASK}, "control readback");
         check_bit(amplifier_power_on, d[10], "amplifier power");
         check_bit(positive_input_select, d[4], "positive select");
         check_word({30'h0, negative_input_select}, {30'h0, d[1:0]}, "negative select");
         check_bit(positive_input_ground, ~d[4], "positive ground");
         check_bit(negative_input_ground, ~NEG_BONDED[d[1:0]], "negative ground");
         check_bit(channel_result_pin_oe_n, ~d[14], "pin enable");
      end
      // unmapped place reads zero and keeps nothing
      wr_reg(4'hC, 32'hFFFF_FFFF);
      bus_xfer(1'b0, 4'hC, 32'h0, r);
      check_word(r, CCEL_ZERO_WORD, "unmapped read");
      // every edge code with and without inversion; a rise then a fall of the raw result
      for (int i = 0; i < 8; i++) begin
         code = i[1:0];
         inv  = i[2];
         c = 16'h4010;
         c[13] = inv;
         c[7:6] = code;
         ref_level <= 8'h00;
         wr_reg(CCEL_ADDR_CONTROL, {16'h0, c});
         c[15] = 1'b1;
         wr_reg(CCEL_ADDR_CONTROL, {16'h0, c});
         repeat (4) @(posedge core_clk);
         wr_reg(CCEL_ADDR_CONTROL, {16'h0, c});
         wr_reg(CCEL_ADDR_STATUS, 32'h1);
         wr_reg(CCEL_ADDR_MASK, 32'h1);
         trig_count = 0;
         ref_level <= 8'h80;
         repeat (8) @(posedge core_clk);
         e1 = (code == 2'b11) || (code == 2'b01 && !inv) || (code == 2'b10 && inv);
         check_word(32'(trig_count), {31'h0, e1}, "events on rise");
         check_bit(channel_result_pin, ~inv, "result pin");
         check_bit(irq, e1, "interrupt");
         check_bit(channel_on, 1'b1, "channel on");
         e = c;
         e[9] = e1;
         e[8] = ~inv;
         bus_xfer(1'b0, CCEL_ADDR_CONTROL, 32'h0, r);
         check_word(r, {16'h0, e}, "control after rise");
         ref_level <= 8'h00;
         repeat (8) @(posedge core_clk);
         e2 = !e1 && ((code == 2'b11) || (code == 2'b01 && inv) || (code == 2'b10 && !inv));
         check_word(32'(trig_count), {31'h0, e1} + {31'h0, e2}, "events on fall");
         bus_xfer(1'b0, CCEL_ADDR_STATUS, 32'h0, r);
         check_word(r, {31'h0, e1 | e2}, "status");
         // switch off but keep the sticky flag as it stands; a plain zero write would clear it
         wr_reg(CCEL_ADDR_CONTROL, {22'h0, e1 | e2, 9'h0});
         bus_xfer(1'b0, CCEL_ADDR_CONTROL, 32'h0, r);
         check_word(r, {22'h0, e1 | e2, 9'h0}, "channel off");
      end
      summarize();
   end
endmodule : tb
